// >>> rtl/txcs_regs.svh
// Register offsets, field positions, reset values and timing counts of the transmit clocking block.
`ifndef TXCS_REGS_SVH
`define TXCS_REGS_SVH
// ==========================================================================
// Register byte offsets.
`define TXCS_OFS_CTRL      8'h00
`define TXCS_OFS_EVENT     8'h04
`define TXCS_OFS_MASK      8'h08
`define TXCS_OFS_STATE     8'h0c
// ==========================================================================
// Control register fields.
`define TXCS_CTRL_SEL      0
`define TXCS_CTRL_RATE     1
`define TXCS_CTRL_HALF     2
`define TXCS_CTRL_RECENTER 3
`define TXCS_CTRL_RESET    4'h8
// ==========================================================================
// Event register fields.
`define TXCS_EV_SLIP       0
`define TXCS_EV_READY      1
// ==========================================================================
// State register fields.
`define TXCS_ST_ERR        0
`define TXCS_ST_FILL_LSB   1
`define TXCS_ST_CHAR_LSB   4
// ==========================================================================
// Timing counts and answer codes.
`define TXCS_SYNC_STAGES   2
`define TXCS_RESP_OKAY     2'h0
`define TXCS_RESP_SLVERR   2'h2
`endif

// >>> rtl/txcs_pkg.sv
// Types shared by the transmit clocking block and its users.
package txcs_pkg;
  // One transmit character: two control bits above eight data bits.
  typedef struct packed {
    logic [1:0] ctrl;
    logic [7:0] data;
  } txcs_char_t;
  // Buffer alignment phases.
  typedef enum logic [0:0] {
    TXCS_ALIGNING = 1'b0,
    TXCS_ALIGNED  = 1'b1
  } txcs_phase_t;
endpackage

// >>> rtl/txcs_top.sv
// Transmit clock selection, phase-align buffer and transmit clock output of one channel.
//
// What this block does
// - Software may choose the reference clock to clock the parallel interface instead.
// - Select latch 0: the input clock samples transmit characters and control bits.
// - Drift beyond buffer capacity raises the error flag until word sync or until the buffer is reinitialised.
// - Writing 0 to the recenter latch initialises the input-to-reference phase.
// - Error flag falling marks the buffer initialised; earlier characters are unreliable.
// - Half-rate reference clocking samples transmit inputs on both reference edges.
// - Half-rate reference clocking updates status outputs on both reference edges.
// - The transmit clock output runs synchronous to the internal character clock.
// - Clock output runs at the reference rate with rate latch 0, double with 1.
// - The clock output has no guaranteed phase relation to the reference input.
// - Characters are captured on the rising edge of the selected interface clock, and on both reference edges at half rate.
// - After slip the error flag holds until word sync or recentering.
`timescale 1ns/10ps
`include "txcs_regs.svh"

module txcs_top #(
  parameter int BUF_DEPTH = 4,
  parameter int HP_WIDTH  = 8
) (
  // Clock and reset.
  input  wire logic                CLK,
  input  wire logic                ARST_N,
  // Link pins from the host.
  input  wire logic                REFERENCE_CLOCK_IN,
  input  wire logic                TX_INPUT_CLOCK,
  input  txcs_pkg::txcs_char_t     TX_CHAR_IN,
  input  wire logic                TX_WORD_SYNC,
  // Character stream toward the encoder and status pins.
  output txcs_pkg::txcs_char_t     TX_CHAR_OUT,
  output logic                     TX_CHAR_STROBE,
  output logic                     TX_PATH_ERROR,
  output logic                     TX_CLOCK_OUT,
  output logic                     IRQ,
  // AXI4-Lite write channels.
  input  wire logic [7:0]          S_AXI_AWADDR,
  input  wire logic                S_AXI_AWVALID,
  output logic                     S_AXI_AWREADY,
  input  wire logic [31:0]         S_AXI_WDATA,
  input  wire logic [3:0]          S_AXI_WSTRB,
  input  wire logic                S_AXI_WVALID,
  output logic                     S_AXI_WREADY,
  output logic [1:0]               S_AXI_BRESP,
  output logic                     S_AXI_BVALID,
  input  wire logic                S_AXI_BREADY,
  // AXI4-Lite read channels.
  input  wire logic [7:0]          S_AXI_ARADDR,
  input  wire logic                S_AXI_ARVALID,
  output logic                     S_AXI_ARREADY,
  output logic [31:0]              S_AXI_RDATA,
  output logic [1:0]               S_AXI_RRESP,
  output logic                     S_AXI_RVALID,
  input  wire logic                S_AXI_RREADY
);
  import txcs_pkg::*;

  localparam int PW = $clog2(BUF_DEPTH);
  localparam logic [PW:0] CENTER = (PW+1)'(BUF_DEPTH / 2);

  // ==========================================================================
  // Pin synchronisers and edge detection.
  localparam int SW = 13;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [1:0]    prev_clk;

  // Two stages for every pin; the first stage feeds nothing but the second.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1    <= '0;
      sync2    <= '0;
      prev_clk <= '0;
    end else begin
      sync1    <= {TX_WORD_SYNC, TX_CHAR_IN, TX_INPUT_CLOCK, REFERENCE_CLOCK_IN};
      sync2    <= sync1;
      prev_clk <= sync2[1:0];
    end
  end

  wire        ref_lvl   = sync2[0];
  wire        ref_rise  = ref_lvl & ~prev_clk[0];
  wire        ref_fall  = ~ref_lvl & prev_clk[0];
  wire        in_rise   = sync2[1] & ~prev_clk[1];
  wire        word_sync = sync2[12];
  txcs_char_t pin_char;
  assign pin_char = txcs_char_t'(sync2[11:2]);

  // ==========================================================================
  // Control latches.
  logic [3:0] ctrl;
  logic [1:0] event_sts;
  logic [1:0] event_mask;
  wire        sel_ref  = ctrl[`TXCS_CTRL_SEL];
  wire        rate_dbl = ctrl[`TXCS_CTRL_RATE];
  wire        half     = ctrl[`TXCS_CTRL_HALF];

  // Character tick: reference rising edge, plus falling edge at half rate.
  wire tick = ref_rise | (half & ref_fall);

  // ==========================================================================
  // Phase-align buffer.
  txcs_char_t  buf_mem [BUF_DEPTH];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic [PW:0]   fill;
  txcs_phase_t   phase;
  logic          slip_err;

  wire buf_full  = (fill == (PW+1)'(BUF_DEPTH));
  wire buf_empty = (fill == '0);
  wire buf_wr    = ~sel_ref & in_rise;
  wire buf_rd    = ~sel_ref & tick & (phase == TXCS_ALIGNED);
  wire do_wr     = buf_wr & ~buf_full;
  wire do_rd     = buf_rd & ~buf_empty;
  wire slip      = (buf_wr & buf_full) | (buf_rd & buf_empty);
  logic recenter;
  wire aligned_now = (phase == TXCS_ALIGNING) & (fill >= CENTER) & ~recenter;

  // Writes come from the input clock, reads from the character tick.
  always_ff @(posedge CLK) begin
    if (do_wr) begin
      buf_mem[wptr] <= pin_char;
    end
  end

  // Pointers; recentering empties the buffer and refills it to half depth.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wptr  <= '0;
      rptr  <= '0;
      fill  <= '0;
      phase <= TXCS_ALIGNING;
    end else if (recenter) begin
      wptr  <= '0;
      rptr  <= '0;
      fill  <= '0;
      phase <= TXCS_ALIGNING;
    end else begin
      wptr  <= wptr + PW'(do_wr);
      rptr  <= rptr + PW'(do_rd);
      fill  <= fill + (PW+1)'(do_wr) - (PW+1)'(do_rd);
      if (aligned_now) begin
        phase <= TXCS_ALIGNED;
      end
    end
  end

  // Slip error sticks until word sync or recenter; a slip wins over clearing.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      slip_err <= 1'b0;
    end else if (slip) begin
      slip_err <= 1'b1;
    end else if (recenter | word_sync) begin
      slip_err <= 1'b0;
    end
  end

  // The flag stays high until alignment completes, so its fall marks readiness.
  wire err_now = ~sel_ref & (slip_err | (phase == TXCS_ALIGNING));

  // ==========================================================================
  // Character output and error pin, moved only on the character tick; the strobe pulses for one cycle after a tick in bypass or with a buffer read.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_CHAR_OUT    <= '0;
      TX_CHAR_STROBE <= 1'b0;
      TX_PATH_ERROR  <= 1'b0;
    end else begin
      TX_CHAR_STROBE <= tick & (sel_ref | do_rd);
      if (tick) begin
        TX_PATH_ERROR <= err_now;
        if (sel_ref) begin
          TX_CHAR_OUT <= pin_char;
        end else if (do_rd) begin
          TX_CHAR_OUT <= buf_mem[rptr];
        end
      end
    end
  end

  // ==========================================================================
  // Transmit clock output: follows the reference, or doubles it using the
  // measured half period; its phase to the reference input is not fixed.
  logic [HP_WIDTH-1:0] hp_cnt;
  logic [HP_WIDTH-1:0] hp_len;
  wire ref_edge = ref_rise | ref_fall;
  wire mid_pt   = (hp_cnt == (hp_len >> 1)) & ~ref_edge;

  // Half-period measurement in system clock cycles.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hp_cnt <= '0;
      hp_len <= '0;
    end else if (ref_edge) begin
      hp_cnt <= '0;
      hp_len <= hp_cnt;
    end else if (hp_cnt != '1) begin
      hp_cnt <= hp_cnt + 1'b1;
    end
  end

  // Clock output generator.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_CLOCK_OUT <= 1'b0;
    end else if (!rate_dbl) begin
      TX_CLOCK_OUT <= ref_lvl;
    end else if (ref_edge) begin
      TX_CLOCK_OUT <= 1'b1;
    end else if (mid_pt) begin
      TX_CLOCK_OUT <= 1'b0;
    end
  end

  // ==========================================================================
  // AXI4-Lite slave.
  logic        aw_got;
  logic        w_got;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire         aw_hs     = S_AXI_AWVALID & S_AXI_AWREADY;
  wire         w_hs      = S_AXI_WVALID & S_AXI_WREADY;
  wire         have_aw   = aw_got | aw_hs;
  wire         have_w    = w_got | w_hs;
  wire         do_write  = have_aw & have_w;
  wire [7:0]   wr_addr   = aw_hs ? S_AXI_AWADDR : aw_addr;
  wire [31:0]  wr_data   = w_hs ? S_AXI_WDATA : w_data;
  wire [3:0]   wr_strb   = w_hs ? S_AXI_WSTRB : w_strb;
  wire         lane0     = do_write & wr_strb[0];
  wire         wr_ctrl   = lane0 & (wr_addr == `TXCS_OFS_CTRL);
  wire         wr_event  = lane0 & (wr_addr == `TXCS_OFS_EVENT);
  wire         wr_mask   = lane0 & (wr_addr == `TXCS_OFS_MASK);
  wire         wr_ok     = (wr_addr == `TXCS_OFS_CTRL) | (wr_addr == `TXCS_OFS_EVENT) |
                           (wr_addr == `TXCS_OFS_MASK) | (wr_addr == `TXCS_OFS_STATE);
  wire         next_aw   = have_aw & ~do_write;
  wire         next_w    = have_w & ~do_write;
  wire         next_bv   = do_write | (S_AXI_BVALID & ~S_AXI_BREADY);
  wire         ar_hs     = S_AXI_ARVALID & S_AXI_ARREADY;
  wire         next_rv   = ar_hs | (S_AXI_RVALID & ~S_AXI_RREADY);
  wire [31:0]  state_word = {18'h0_0000, TX_CHAR_OUT, fill[2:0], err_now};

  assign recenter = wr_ctrl & ~wr_data[`TXCS_CTRL_RECENTER];

  // Read mux; unmapped addresses answer zero with an error response.
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (S_AXI_ARADDR)
      `TXCS_OFS_CTRL:  rd_word = {28'h000_0000, ctrl};
      `TXCS_OFS_EVENT: rd_word = {30'h0000_0000, event_sts};
      `TXCS_OFS_MASK:  rd_word = {30'h0000_0000, event_mask};
      `TXCS_OFS_STATE: rd_word = state_word;
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b0;
      end
    endcase
  end

  // Write address and data are taken in either order; response follows both.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `TXCS_RESP_OKAY;
    end else begin
      aw_got        <= next_aw;
      w_got         <= next_w;
      S_AXI_AWREADY <= ~next_aw & ~next_bv;
      S_AXI_WREADY  <= ~next_w & ~next_bv;
      S_AXI_BVALID  <= next_bv;
      if (aw_hs) begin
        aw_addr <= S_AXI_AWADDR;
      end
      if (w_hs) begin
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        S_AXI_BRESP <= wr_ok ? `TXCS_RESP_OKAY : `TXCS_RESP_SLVERR;
      end
    end
  end

  // Read channel: one read at a time, data held until taken.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `TXCS_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ~next_rv;
      S_AXI_RVALID  <= next_rv;
      if (ar_hs) begin
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= rd_ok ? `TXCS_RESP_OKAY : `TXCS_RESP_SLVERR;
      end
    end
  end

  // ==========================================================================
  // Control latches, sticky events and interrupt; an event beats its clear.
  wire [1:0] ev_set = {aligned_now, slip};
  wire [1:0] ev_clr = wr_event ? wr_data[1:0] : 2'b00;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl       <= `TXCS_CTRL_RESET;
      event_sts  <= 2'b00;
      event_mask <= 2'b00;
      IRQ        <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wr_data[3:0];
      end
      if (wr_mask) begin
        event_mask <= wr_data[1:0];
      end
      event_sts <= (event_sts & ~ev_clr) | ev_set;
      IRQ       <= |(((event_sts & ~ev_clr) | ev_set) & event_mask);
    end
  end

  // ==========================================================================
  // Checks.
  // A slip in the very cycle of a recenter still wins, so that cycle is left out.
  sequence seq_recenter;
    recenter && !slip;
  endsequence

  sequence seq_buf_cleared;
    fill == '0 && phase == TXCS_ALIGNING && !slip_err;
  endsequence

  chk_recenter_inits: assert property (
    @(posedge CLK) disable iff (!ARST_N) seq_recenter |=> seq_buf_cleared)
    else $error("Recenter did not clear the buffer state.");

  chk_slip_sticky: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    slip_err && !recenter && !word_sync |=> slip_err)
    else $error("Slip error dropped without recenter or word sync.");

  chk_slip_sets: assert property (
    @(posedge CLK) disable iff (!ARST_N) slip |=> slip_err)
    else $error("Buffer slip did not raise the error.");

  chk_half_rate_tick: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    half && ref_fall |=> TX_CHAR_STROBE || (!$past(sel_ref) && !$past(do_rd)))
    else $error("Falling reference edge ignored at half rate.");

  chk_full_rate_fall: assert property (
    @(posedge CLK) disable iff (!ARST_N) !half && ref_fall |=> !TX_CHAR_STROBE)
    else $error("Falling reference edge used at full rate.");

  chk_bypass_sample: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    tick && sel_ref |=> TX_CHAR_OUT == $past(pin_char) && TX_CHAR_STROBE)
    else $error("Bypass path did not sample the pins.");

  chk_err_pin_tick: assert property (
    @(posedge CLK) disable iff (!ARST_N) !tick |=> $stable(TX_PATH_ERROR))
    else $error("Error pin moved off the character tick.");

  chk_clkout_rate0: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    !rate_dbl && ref_rise ##1 !rate_dbl |-> TX_CLOCK_OUT)
    else $error("Clock output does not follow the reference.");

  chk_wr_capture: assert property (
    @(posedge CLK) disable iff (!ARST_N) do_wr && !recenter |=> fill != '0)
    else $error("Input clock edge did not load the buffer.");
endmodule

// >>> verification/txcs_host_model.sv
// Host-side model that drives the transmit input clock and characters.
`timescale 1ns/10ps
module txcs_host_model (
  // Link clock and control from the bench.
  input  wire logic            ref_clk,
  input  wire logic            stall,
  // Pins toward the block.
  output logic                 tx_clk,
  output txcs_pkg::txcs_char_t chr
);
  import txcs_pkg::*;
  // The input clock copies the reference 40 ns late; a stall parks it low like its pull-down.
  initial tx_clk = 1'b0;
  always @(ref_clk) begin
    tx_clk <= #40 (stall ? 1'b0 : ref_clk);
  end
  // A new character follows each falling input clock, so it is steady at the rising one.
  initial chr = '0;
  always @(negedge tx_clk) begin
    chr <= txcs_char_t'(chr + 10'h001);
  end
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the transmit clocking block.
`timescale 1ns/10ps
`include "txcs_regs.svh"
module testbench;
  import txcs_pkg::*;
  logic       clk, arst_n, ref_clk, stall, word_sync;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic       awvalid, wvalid, bready, arvalid, rready;
  logic       awready, wready, bvalid, arready, rvalid;
  logic       strobe, err, clk_out, irq;
  logic       tx_clk;
  logic [1:0] bresp, rresp;
  txcs_char_t chr_in, chr_out, prev_chr;
  int         n_fail = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         ns, nc;

  // Device under test and the host model on its link side.
  txcs_top txcs_top_i (
    .CLK(clk), .ARST_N(arst_n), .REFERENCE_CLOCK_IN(ref_clk),
    .TX_INPUT_CLOCK(tx_clk), .TX_CHAR_IN(chr_in), .TX_WORD_SYNC(word_sync),
    .TX_CHAR_OUT(chr_out), .TX_CHAR_STROBE(strobe), .TX_PATH_ERROR(err),
    .TX_CLOCK_OUT(clk_out), .IRQ(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );
  txcs_host_model txcs_host_model_i (
    .ref_clk(ref_clk), .stall(stall), .tx_clk(tx_clk), .chr(chr_in)
  );

  // System clock and a reference clock of 160 ns with an unrelated phase.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    ref_clk = 1'b0;
    #7;
    forever #80 ref_clk = ~ref_clk;
  end

  // Hang guard: a run that overstays counts as a mismatch.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // Verdict and end of run.
  task automatic wrap_up();
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Compares one value and reports a mismatch.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One register write; both channels are offered together and released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(er));
    @(posedge clk);
  endtask

  // One register read with expected data and response.
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rdata", rdata, ed);
    chk("rresp", 32'(rresp), 32'(er));
    @(posedge clk);
  endtask

  // Waits a bounded time for the error flag to reach a level.
  task automatic wait_err(input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (err !== v && n < lim);
    chk("error flag", 32'(err), 32'(v));
  endtask

  // Waits a bounded time for a character strobe.
  task automatic wait_strobe();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (strobe !== 1'b1 && n < 40);
    chk("strobe", 32'(strobe), 32'h0000_0001);
  endtask

  // Counts strobes and clock-out rises over 64 cycles, i.e. 8 reference periods.
  task automatic count64();
    logic prev;
    ns = 0;
    nc = 0;
    prev = clk_out;
    repeat (64) begin
      @(posedge clk);
      if (strobe === 1'b1) ns++;
      if (clk_out === 1'b1 && prev === 1'b0) nc++;
      prev = clk_out;
    end
  endtask

  // Reset values, unmapped place and a quiet interrupt line.
  task automatic t_reset();
    rd(`TXCS_OFS_EVENT, 32'h0000_0000, `TXCS_RESP_OKAY);
    rd(`TXCS_OFS_CTRL, 32'h0000_0008, `TXCS_RESP_OKAY);
    rd(`TXCS_OFS_MASK, 32'h0000_0000, `TXCS_RESP_OKAY);
    rd(`TXCS_OFS_STATE, 32'h0000_0001, `TXCS_RESP_OKAY);
    rd(8'h10, 32'h0000_0000, `TXCS_RESP_SLVERR);
    wr(8'h10, 32'h0000_ffff, `TXCS_RESP_SLVERR);
    chk("irq", 32'(irq), 32'h0000_0000);
  endtask

  // Reference clock drives the interface directly, at full and at half rate.
  task automatic t_bypass();
    wr(`TXCS_OFS_CTRL, 32'h0000_0009, `TXCS_RESP_OKAY);
    wait_strobe();
    wait_strobe();
    chk("bypass char", 32'(chr_out), 32'(chr_in));
    count64();
    chk("strobes full rate", ns, 8);
    chk("clock out rate 0", nc, 8);
    chk("error in bypass", 32'(err), 32'h0000_0000);
    wr(`TXCS_OFS_CTRL, 32'h0000_000b, `TXCS_RESP_OKAY);
    wait_strobe();
    count64();
    chk("clock out rate 1", nc, 16);
    wr(`TXCS_OFS_CTRL, 32'h0000_000f, `TXCS_RESP_OKAY);
    wait_strobe();
    count64();
    chk("strobes half rate", ns, 16);
  endtask

  // Recenter, alignment and the character stream through the phase-align buffer.
  task automatic t_align();
    wr(`TXCS_OFS_MASK, 32'h0000_0001, `TXCS_RESP_OKAY);
    wr(`TXCS_OFS_CTRL, 32'h0000_0000, `TXCS_RESP_OKAY);
    wr(`TXCS_OFS_EVENT, 32'h0000_0003, `TXCS_RESP_OKAY);
    // The flag may still show the bypass value, so see it rise before it falls.
    wait_err(1'b1, 20);
    wait_err(1'b0, 300);
    rd(`TXCS_OFS_EVENT, 32'h0000_0002, `TXCS_RESP_OKAY);
    chk("irq masked", 32'(irq), 32'h0000_0000);
    wait_strobe();
    prev_chr = chr_out;
    wait_strobe();
    chk("next char", 32'(chr_out), 32'(10'(prev_chr + 10'h001)));
    count64();
    chk("strobes aligned", ns, 8);
    chk("error aligned", 32'(err), 32'h0000_0000);
  endtask

  // Host stalls: the slip is flagged, stays sticky and is cleared by recentering.
  task automatic t_slip();
    stall <= 1'b1;
    wait_err(1'b1, 100);
    chk("irq slip", 32'(irq), 32'h0000_0001);
    rd(`TXCS_OFS_EVENT, 32'h0000_0003, `TXCS_RESP_OKAY);
    stall <= 1'b0;
    count64();
    chk("error sticky", 32'(err), 32'h0000_0001);
    // Park in bypass first so that no slip can land in the recenter cycle itself.
    wr(`TXCS_OFS_CTRL, 32'h0000_0009, `TXCS_RESP_OKAY);
    wr(`TXCS_OFS_CTRL, 32'h0000_0000, `TXCS_RESP_OKAY);
    wr(`TXCS_OFS_EVENT, 32'h0000_0003, `TXCS_RESP_OKAY);
    wait_err(1'b1, 20);
    wait_err(1'b0, 300);
    rd(`TXCS_OFS_EVENT, 32'h0000_0002, `TXCS_RESP_OKAY);
    chk("irq cleared", 32'(irq), 32'h0000_0000);
    wr(`TXCS_OFS_MASK, 32'h0000_0002, `TXCS_RESP_OKAY);
    chk("irq unmasked", 32'(irq), 32'h0000_0001);
    wr(`TXCS_OFS_EVENT, 32'h0000_0002, `TXCS_RESP_OKAY);
    chk("irq after clear", 32'(irq), 32'h0000_0000);
  endtask

  // Main sequence.
  initial begin
    arst_n = 1'b0;
    stall = 1'b1;
    word_sync = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    stall <= 1'b0;
    t_bypass();
    t_align();
    t_slip();
    wrap_up();
  end
endmodule
